// >>> rtl/adc_power_mode_control.sv
// Power-mode controller for a sampling converter: decodes the power
// select field and the sleep pin, sequences power-down and wake-up.
// Assumes busy comes from converter logic on clk_sys; pins are async.
//
// Behaviour
// [R01] Mode from select bits and sleep pin
// [R02] Full power-down turns everything off
// [R03] Partial power-down keeps reference alive
// [R04] Select bits reset to zero
// [R05] 00 with sleep high: always powered
// [R06] 00 with sleep low: full down between
// [R07] 01: normal operation, sleep ignored
// [R08] 10: full power-down, sleep ignored
// [R09] 11: partial down between conversions
// [R10] Host holds sleep high for software control
// [R11] Host may pull sleep low at low rates
// [R12] Busy falling edge enters power-down
// [R13] Start pulse falling edge wakes, 5 us
// [R14] Host powers up before software start
// [R15] Field applies at write; sleep synchronised
`timescale 1ns/1ps
`default_nettype none
module adc_power_mode_control (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic sleep_n,
   input wire logic sample_go_n,
   input wire logic busy,
   output logic core_power_on,
   output logic ref_power_on,
   output logic powered_ready
);
   // ----------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------
   logic sleep_meta, sleep_sync;
   logic go_meta, go_sync, go_prev;
   logic busy_prev;
   // [R15] sleep pin synchronised
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sleep_meta <= 1'b1;
         sleep_sync <= 1'b1;
         go_meta <= 1'b1;
         go_sync <= 1'b1;
         go_prev <= 1'b1;
         busy_prev <= 1'b0;
      end else begin
         sleep_meta <= sleep_n;
         sleep_sync <= sleep_meta;
         go_meta <= sample_go_n;
         go_sync <= go_meta;
         go_prev <= go_sync;
         busy_prev <= busy;
      end
   end
   logic go_fall, busy_fall;
   assign go_fall = go_prev && !go_sync;
   assign busy_fall = busy_prev && !busy;

   // ----------------------------------------
   // Avalon-MM slave: one wait cycle per access
   // ----------------------------------------
   logic [1:0] pwr_sel;
   logic accept;
   assign accept = (read || write) && !waitrequest;
   // Waitrequest drops for exactly one cycle after a request appears
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end
   // [R04] select resets to zero
   // [R15] field applies at write completion
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pwr_sel <= pwr_mode_pkg::SEL_RESET;
      end else if (accept && write && address == pwr_mode_pkg::CTRL_ADDR && byteenable[0]) begin
         pwr_sel <= writedata[1:0];
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   pwr_mode_pkg::pwr_mode_t mode;
   // [R01] decode from bits and pin
   always_comb begin
      unique case (pwr_sel)
         2'h0: mode = sleep_sync ? pwr_mode_pkg::MODE_FULL_UP : pwr_mode_pkg::MODE_PD_FULL_BETWEEN;
         2'h1: mode = pwr_mode_pkg::MODE_NORMAL;
         2'h2: mode = pwr_mode_pkg::MODE_FULL_DOWN;
         2'h3: mode = pwr_mode_pkg::MODE_PD_PART_BETWEEN;
      endcase
   end
   logic between;
   assign between = mode == pwr_mode_pkg::MODE_PD_FULL_BETWEEN || mode == pwr_mode_pkg::MODE_PD_PART_BETWEEN;

   // ----------------------------------------
   // Power sequencer
   // ----------------------------------------
   pwr_mode_pkg::pwr_state_t state, next_state;
   logic [7:0] wake_cnt;
   always_comb begin
      next_state = state;
      unique case (state)
         pwr_mode_pkg::ST_ON: begin
            // [R08] forced full power-down
            if (mode == pwr_mode_pkg::MODE_FULL_DOWN) begin
               next_state = pwr_mode_pkg::ST_DOWN;
            // [R12] sleep at end of conversion
            end else if (between && busy_fall) begin
               next_state = pwr_mode_pkg::ST_DOWN;
            end
         end
         pwr_mode_pkg::ST_DOWN: begin
            // [R05] [R07] always-on modes wake at once
            if (mode == pwr_mode_pkg::MODE_FULL_UP || mode == pwr_mode_pkg::MODE_NORMAL) begin
               next_state = pwr_mode_pkg::ST_WAKING;
            // [R13] start pulse falling edge wakes
            end else if (between && go_fall) begin
               next_state = pwr_mode_pkg::ST_WAKING;
            end
         end
         pwr_mode_pkg::ST_WAKING: begin
            if (mode == pwr_mode_pkg::MODE_FULL_DOWN) begin
               next_state = pwr_mode_pkg::ST_DOWN;
            end else if (wake_cnt == 8'h00) begin
               next_state = pwr_mode_pkg::ST_ON;
            end
         end
      endcase
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= pwr_mode_pkg::ST_ON;
      end else begin
         state <= next_state;
      end
   end
   // [R13] wake time counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_cnt <= 8'h00;
      end else if (state != pwr_mode_pkg::ST_WAKING) begin
         wake_cnt <= 8'(pwr_mode_pkg::WAKE_CYC - 1);
      end else if (wake_cnt != 8'h00) begin
         wake_cnt <= wake_cnt - 8'h01;
      end
   end
   // Outputs follow next_state so they match state in the same cycle
   // [R02] [R03] [R06] [R09] core and reference enables
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         core_power_on <= 1'b1;
         ref_power_on <= 1'b1;
         powered_ready <= 1'b1;
      end else begin
         core_power_on <= next_state != pwr_mode_pkg::ST_DOWN;
         ref_power_on <= next_state != pwr_mode_pkg::ST_DOWN || mode == pwr_mode_pkg::MODE_PD_PART_BETWEEN;
         powered_ready <= next_state == pwr_mode_pkg::ST_ON;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Unmapped addresses read zero; writes there are dropped
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         readdata <= 32'h0000_0000;
         if (address == pwr_mode_pkg::CTRL_ADDR) begin
            readdata[1:0] <= pwr_sel;
         end else if (address == pwr_mode_pkg::STATUS_ADDR) begin
            readdata[pwr_mode_pkg::ST_CORE_BIT] <= core_power_on;
            readdata[pwr_mode_pkg::ST_REF_BIT] <= ref_power_on;
            readdata[pwr_mode_pkg::ST_READY_BIT] <= powered_ready;
            readdata[pwr_mode_pkg::ST_SLEEP_BIT] <= sleep_sync;
            readdata[pwr_mode_pkg::ST_MODE_LSB +: 3] <= mode;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_wake_trigger;
      state == pwr_mode_pkg::ST_DOWN && between && go_fall;
   endsequence
   // Pins the wake length exactly: still waking in the last counted cycle, on in the next
   sequence s_wake_run;
      (state == pwr_mode_pkg::ST_WAKING)[*8] ##92 (state == pwr_mode_pkg::ST_WAKING && !powered_ready)
      ##1 (state == pwr_mode_pkg::ST_ON && powered_ready);
   endsequence
   chk_full_up_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // [R05]
      (state == pwr_mode_pkg::ST_ON && mode == pwr_mode_pkg::MODE_FULL_UP) |=> state == pwr_mode_pkg::ST_ON)
      else $error("full power-up left the on state");
   chk_normal_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // [R07]
      (state == pwr_mode_pkg::ST_ON && mode == pwr_mode_pkg::MODE_NORMAL) |=> core_power_on && powered_ready)
      else $error("normal operation powered down");
   chk_forced_down: assert property (@(posedge clk_sys) disable iff (!resetn) // [R08]
      mode == pwr_mode_pkg::MODE_FULL_DOWN |=> state == pwr_mode_pkg::ST_DOWN)
      else $error("forced power-down not entered");
   // Outputs are launched from next_state, so they line up with state in the same cycle;
   // the reference enable was computed from the mode of the cycle before
   chk_full_down_off: assert property (@(posedge clk_sys) disable iff (!resetn) // [R02]
      (state == pwr_mode_pkg::ST_DOWN && $past(mode) != pwr_mode_pkg::MODE_PD_PART_BETWEEN)
      |-> !core_power_on && !ref_power_on)
      else $error("full power-down left something on");
   chk_partial_ref_on: assert property (@(posedge clk_sys) disable iff (!resetn) // [R03]
      (state == pwr_mode_pkg::ST_DOWN && $past(mode) == pwr_mode_pkg::MODE_PD_PART_BETWEEN)
      |-> !core_power_on && ref_power_on)
      else $error("partial power-down dropped the reference");
   chk_busy_fall_down: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
      (state == pwr_mode_pkg::ST_ON && between && busy_fall) |=> state == pwr_mode_pkg::ST_DOWN)
      else $error("no power-down after conversion end");
   chk_sleep_low_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // [R06]
      (pwr_sel == 2'h0 && !sleep_sync) |-> mode == pwr_mode_pkg::MODE_PD_FULL_BETWEEN)
      else $error("sleep low did not select full power-down between");
   chk_wake_time: assert property (@(posedge clk_sys) disable iff (!resetn || pwr_sel == 2'h2) // [R13]
      s_wake_trigger |=> s_wake_run)
      else $error("wake-up did not take the set time");
   chk_sel_write: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
      (accept && write && address == pwr_mode_pkg::CTRL_ADDR && byteenable[0])
      |=> pwr_sel == $past(writedata[1:0]))
      else $error("select field not taken from write");
endmodule
`default_nettype wire

// >>> rtl/pwr_mode_pkg.sv
// Constants for the converter power-mode controller.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
package pwr_mode_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int SEL_LO_BIT = 0;
   localparam int SEL_HI_BIT = 1;
   localparam logic [1:0] SEL_RESET = 2'h0;
   // Status fields
   localparam int ST_CORE_BIT = 0;
   localparam int ST_REF_BIT = 1;
   localparam int ST_READY_BIT = 2;
   localparam int ST_SLEEP_BIT = 3;
   localparam int ST_MODE_LSB = 4;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int WAKE_NS = 5000;
   localparam int WAKE_CYC = (WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_FULL_UP, MODE_PD_FULL_BETWEEN, MODE_NORMAL, MODE_FULL_DOWN, MODE_PD_PART_BETWEEN
   } pwr_mode_t;
   typedef enum logic [1:0] {ST_ON, ST_DOWN, ST_WAKING} pwr_state_t;
endpackage

// >>> verif/host_pin_model.sv
// Host and converter pin model: sleep level, start pulse, busy.
// Assumes one clk_sys domain; the bench asks for a conversion with go.
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic sleep_req,
   output logic sleep_n,
   output logic sample_go_n,
   output logic busy
);
   int cnt = 0;
   // sleep pin held high unless low power is wanted
   assign sleep_n = !sleep_req;
   // Conversion frame counter; a new go is ignored mid-frame
   always @(posedge clk_sys) begin
      if (go && cnt == 0) cnt <= 1;
      else if (cnt != 0) cnt <= (cnt == 140) ? 0 : cnt + 1;
   end
   // start pulse kept low 6 us, well past the wake time
   assign sample_go_n = !(cnt >= 1 && cnt <= 120);
   assign busy = cnt > 120 && cnt < 136;
endmodule
`default_nettype wire

// >>> verif/adc_power_mode_control_bench.sv
// Self-checking bench for the power-mode controller.
// Assumes the Avalon port answers with a registered waitrequest.
`timescale 1ns/1ps
`default_nettype none
module adc_power_mode_control_bench;
   logic clk_sys = 0, resetn = 0, read = 0, write = 0, go = 0, sleep_req = 0;
   logic [3:0] address = 4'h0, byteenable = 4'hF;
   logic [31:0] writedata = 32'h0, readdata, rdata;
   logic waitrequest, sleep_n, sample_go_n, busy, core_power_on, ref_power_on, powered_ready;
   int bad_count = 0, check_count = 0;
   // ----------------------------------------
   // Clock, parts and shared tasks
   // ----------------------------------------
   initial forever #25 clk_sys = !clk_sys;
   host_pin_model pins (.clk_sys(clk_sys), .go(go), .sleep_req(sleep_req), .sleep_n(sleep_n),
      .sample_go_n(sample_go_n), .busy(busy));
   adc_power_mode_control dut (.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .sleep_n(sleep_n), .sample_go_n(sample_go_n), .busy(busy),
      .core_power_on(core_power_on), .ref_power_on(ref_power_on), .powered_ready(powered_ready));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then frees the bus
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rdata = readdata;
      read <= 0;
      write <= 0;
      @(posedge clk_sys);
   endtask
   task automatic pulse(input int n);
      go <= 1;
      @(posedge clk_sys);
      go <= 0;
      repeat (n) @(posedge clk_sys);
   endtask
   // Lets one edge pass: outputs launched by the last bus edge are only visible after it
   task automatic pw(input logic [2:0] exp);
      @(posedge clk_sys);
      chk("power outputs", {29'h0, exp}, {29'h0, core_power_on, ref_power_on, powered_ready});
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      bus(0, pwr_mode_pkg::CTRL_ADDR, 32'h0, 4'hF);
      chk("ctrl after reset", 32'h0, rdata);
      pw(3'b111);
   endtask
   // Every field value with both sleep levels, mode read back
   task automatic t_modes;
      for (int s = 0; s < 4; s++) begin
         for (int slp = 0; slp < 2; slp++) begin
            sleep_req <= slp[0];
            repeat (4) @(posedge clk_sys);
            bus(1, pwr_mode_pkg::CTRL_ADDR, {30'h0, s[1:0]}, 4'hF);
            if (s == 2) pw(3'b000);
            bus(0, pwr_mode_pkg::STATUS_ADDR, 32'h0, 4'hF);
            chk("mode", (s == 0) ? slp : s + 1, {29'h0, rdata[6:4]});
            chk("sleep sync", {31'h0, !slp[0]}, {31'h0, rdata[3]});
         end
      end
      sleep_req <= 0;
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h1, 4'hF);
      repeat (110) @(posedge clk_sys);
      pw(3'b111);
   endtask
   // Partial down keeps the reference; start pulse wakes in 5 us
   task automatic t_part;
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h3, 4'hF);
      pulse(150);
      pw(3'b010);
      pulse(60);
      pw(3'b110);
      repeat (55) @(posedge clk_sys);
      pw(3'b111);
      repeat (40) @(posedge clk_sys);
      pw(3'b010);
   endtask
   // Sleep pin low with field 00 drops everything between conversions
   task automatic t_full_between;
      sleep_req <= 1;
      repeat (4) @(posedge clk_sys);
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h0, 4'hF);
      pw(3'b000);
      pulse(115);
      pw(3'b111);
      repeat (40) @(posedge clk_sys);
      pw(3'b000);
   endtask
   // Refused writes, unmapped read, busy ignored in always-on modes
   task automatic t_refused;
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h1, 4'h0);
      bus(1, pwr_mode_pkg::STATUS_ADDR, 32'h7F, 4'hF);
      bus(0, pwr_mode_pkg::CTRL_ADDR, 32'h0, 4'hF);
      chk("ctrl masked write", 32'h0, rdata);
      bus(0, 4'h8, 32'h0, 4'hF);
      chk("unmapped read", 32'h0, rdata);
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h1, 4'hF);
      pulse(150);
      pw(3'b111);
      sleep_req <= 0;
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h0, 4'hF);
      pulse(150);
      pw(3'b111);
   endtask
   // Forced power-down during a wake-up sends the core back down
   task automatic t_abort;
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h2, 4'hF);
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h1, 4'hF);
      pw(3'b110);
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h2, 4'hF);
      pw(3'b000);
      bus(1, pwr_mode_pkg::CTRL_ADDR, 32'h1, 4'hF);
      repeat (110) @(posedge clk_sys);
      pw(3'b111);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1;
      @(posedge clk_sys);
      t_reset();
      t_modes();
      t_part();
      t_full_between();
      t_refused();
      t_abort();
      end_of_test();
   end
   // Watchdog: the tests need about 1150 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
